// >>> hdl/isd_core.sv
// synthesizer digital core: serial port, dividers, phase and lock detect
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// What this block does
// - three-wire serial port, receive only
// - frames are exactly 25 bits
// - low sixteen frame bits are payload
// - bits 20..16 select target register
// - bits 24..21 must match chip code
// - 11-bit reference divider feeds phase detector
// - reference ratio 1 through 2047
// - dual-modulus prescaler, 13-bit main, 5-bit swallow
// - ratio equals prescaler times main plus swallow
// - ratio valid from prescaler squared upward; small prescaler also needs ratio bit 17 clear
// - detector gives lead and lag pulses
// - positive phase lead, negative phase lag
// - only rising edges of inputs count
// - lock after enough short-gap comparison cycles
// - lock output high only while locked
// - high word bits 1..0 are ratio MSBs
// - low word gives sixteen ratio LSBs
// - data sampled on serial clock rising edge
////////////////////////////////////////////////////////////////////////////
module isd_core #(
  parameter logic [3:0] CHIP_CODE = 4'h9 // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ser_clk,
  input wire logic latch_strobe,
  input wire logic ser_data,
  input wire logic vco_in,
  output logic lead_pulse,
  output logic lag_pulse,
  output logic lock_flag
);

  ////////////////////////////////////////////////////////////////////////
  // serial write port

  logic ser_clk_q;
  logic latch_q;
  logic ser_rise;
  logic latch_rise;
  logic [24:0] shift_r;
  logic [5:0] bit_cnt_r;
  isd_pkg::isd_frame_s frame;
  logic frame_take;
  logic frame_drop;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ser_clk_q <= 1'b1;
      latch_q <= 1'b1;
    end
    else
    begin
      ser_clk_q <= ser_clk;
      latch_q <= latch_strobe;
    end
  end

  assign ser_rise = ser_clk && !ser_clk_q;
  assign latch_rise = latch_strobe && !latch_q;

  // the count saturates so an overlong frame can never wrap back to 25
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      shift_r <= '0;
      bit_cnt_r <= '0;
    end
    else if (latch_rise)
    begin
      bit_cnt_r <= '0;
    end
    else if (ser_rise && !latch_strobe)
    begin
      shift_r <= {shift_r[23:0], ser_data};
      if (bit_cnt_r != isd_pkg::CNT_MAX)
      begin
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
    end
  end

  assign frame = shift_r;
  assign frame_take = latch_rise &&
                      (bit_cnt_r == isd_pkg::FRAME_LEN) &&
                      (frame.chip == CHIP_CODE);
  // an idle strobe pulse with no bits shifted is not a frame at all
  assign frame_drop = latch_rise && !frame_take && (bit_cnt_r != '0);

  ////////////////////////////////////////////////////////////////////////
  // divider words written over the serial port

  logic [15:0] ref_word_r;
  logic [15:0] fb_low_r;
  logic [15:0] fb_high_r;
  logic [7:0] frames_ok_r;
  logic [7:0] frames_drop_r;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ref_word_r <= isd_pkg::REF_WORD_RST;
      fb_low_r <= isd_pkg::FB_LOW_RST;
      fb_high_r <= isd_pkg::FB_HIGH_RST;
    end
    else if (frame_take)
    begin
      if (frame.addr == isd_pkg::SADDR_REF)
      begin
        ref_word_r <= frame.data;
      end
      else if (frame.addr == isd_pkg::SADDR_FB_LOW)
      begin
        fb_low_r <= frame.data;
      end
      else if (frame.addr == isd_pkg::SADDR_FB_HIGH)
      begin
        fb_high_r <= frame.data;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      frames_ok_r <= '0;
      frames_drop_r <= '0;
    end
    else
    begin
      if (frame_take)
      begin
        frames_ok_r <= frames_ok_r + 8'h01;
      end
      if (frame_drop)
      begin
        frames_drop_r <= frames_drop_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state so read data comes from a flop

  logic [11:0] ctrl_r;
  logic pready_r;
  logic [31:0] prdata_r;
  logic addr_ok;
  logic [31:0] rd_val;
  logic lock_r;
  logic ratio_err;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_val = '0;
    if (paddr == isd_pkg::OFS_CTRL)
    begin
      rd_val = {20'h00000, ctrl_r};
    end
    else if (paddr == isd_pkg::OFS_REF)
    begin
      rd_val = {16'h0000, ref_word_r};
    end
    else if (paddr == isd_pkg::OFS_FB)
    begin
      rd_val = {14'h0000, fb_high_r[1:0], fb_low_r};
    end
    else if (paddr == isd_pkg::OFS_STATUS)
    begin
      rd_val = '0;
      rd_val[isd_pkg::ST_LOCK_BIT] = lock_r;
      rd_val[isd_pkg::ST_RATIO_ERR_BIT] = ratio_err;
      rd_val[isd_pkg::ST_OK_LSB +: 8] = frames_ok_r;
      rd_val[isd_pkg::ST_DROP_LSB +: 8] = frames_drop_r;
    end
    else
    begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= psel && penable && !pready_r;
      if (psel && penable && !pready_r && !pwrite)
      begin
        prdata_r <= rd_val;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= isd_pkg::CTRL_RST;
    end
    else if (psel && penable && pready_r && pwrite &&
             (paddr == isd_pkg::OFS_CTRL))
    begin
      ctrl_r <= pwdata[11:0];
    end
  end

  assign pready = pready_r;
  assign pslverr = pready_r && !addr_ok;
  assign prdata = prdata_r;

  ////////////////////////////////////////////////////////////////////////
  // reference divider

  logic ref_wrap;

  isd_div #(
    .W(11)
  ) u_ref_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(1'b1),
    .ratio(ref_word_r[10:0]),
    .wrap(ref_wrap)
  );

  ////////////////////////////////////////////////////////////////////////
  // feedback divider: dual-modulus prescaler, main and swallow counters

  logic [17:0] n_ratio;
  logic presc_big;
  logic [5:0] presc_base;
  logic [12:0] main_m;
  logic [4:0] swallow_s;
  logic vco_q;
  logic vco_rise;
  logic [5:0] pre_cnt_r;
  logic [5:0] pre_last;
  logic pre_wrap;
  logic [4:0] swallow_left_r;
  logic fb_wrap;

  assign n_ratio = {fb_high_r[1:0], fb_low_r};
  assign presc_big = ctrl_r[isd_pkg::CTRL_PRESC_BIT];
  assign presc_base = presc_big ? isd_pkg::PRESC_BIG : isd_pkg::PRESC_SMALL;
  // split n into main and swallow so that n = base * m + s
  assign main_m = presc_big ? n_ratio[17:5] : n_ratio[16:4];
  assign swallow_s = presc_big ? n_ratio[4:0] : {1'b0, n_ratio[3:0]};
  // below base squared the swallow count can exceed main and n is wrong
  assign ratio_err = presc_big ?
                     (n_ratio < isd_pkg::NMIN_BIG) :
                     ((n_ratio < isd_pkg::NMIN_SMALL) || n_ratio[17]);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      vco_q <= 1'b0;
    end
    else
    begin
      vco_q <= vco_in;
    end
  end

  assign vco_rise = vco_in && !vco_q;
  // divide by base+1 while swallow cycles remain, by base after
  assign pre_last = (swallow_left_r != '0) ? presc_base :
                    presc_base - 6'h01;
  assign pre_wrap = vco_rise && (pre_cnt_r >= pre_last);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pre_cnt_r <= '0;
    end
    else if (pre_wrap)
    begin
      pre_cnt_r <= '0;
    end
    else if (vco_rise)
    begin
      pre_cnt_r <= pre_cnt_r + 6'h01;
    end
  end

  isd_div #(
    .W(13)
  ) u_main_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(pre_wrap),
    .ratio(main_m),
    .wrap(fb_wrap)
  );

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      swallow_left_r <= '0;
    end
    else if (fb_wrap)
    begin
      swallow_left_r <= swallow_s;
    end
    else if (pre_wrap && (swallow_left_r != '0))
    begin
      swallow_left_r <= swallow_left_r - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase detector on the rising edges of both divider outputs

  logic ref_ev;
  logic fb_ev;
  isd_pkg::isd_pfd_e pfd_r;
  isd_pkg::isd_pfd_e pfd_nxt;
  logic cmp_done;
  logic lead_r;
  logic lag_r;
  logic [7:0] gap_r;

  // a wrap strobe is high one cycle per divided edge, every cycle at ratio 1, so each cycle marks one edge
  assign ref_ev = ref_wrap;
  assign fb_ev = fb_wrap;

  always_comb
  begin
    pfd_nxt = pfd_r;
    cmp_done = 1'b0;
    case (pfd_r)
      isd_pkg::PFD_IDLE:
      begin
        if (ref_ev && fb_ev)
        begin
          cmp_done = 1'b1;
        end
        else if (ref_ev)
        begin
          pfd_nxt = isd_pkg::PFD_LEAD;
        end
        else if (fb_ev)
        begin
          pfd_nxt = isd_pkg::PFD_LAG;
        end
      end
      isd_pkg::PFD_LEAD:
      begin
        if (fb_ev)
        begin
          pfd_nxt = isd_pkg::PFD_IDLE;
          cmp_done = 1'b1;
        end
      end
      isd_pkg::PFD_LAG:
      begin
        if (ref_ev)
        begin
          pfd_nxt = isd_pkg::PFD_IDLE;
          cmp_done = 1'b1;
        end
      end
      default:
      begin
        pfd_nxt = isd_pkg::PFD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pfd_r <= isd_pkg::PFD_IDLE;
      lead_r <= 1'b0;
      lag_r <= 1'b0;
    end
    else
    begin
      pfd_r <= pfd_nxt;
      lead_r <= (pfd_nxt == isd_pkg::PFD_LEAD);
      lag_r <= (pfd_nxt == isd_pkg::PFD_LAG);
    end
  end

  assign lead_pulse = lead_r;
  assign lag_pulse = lag_r;

  ////////////////////////////////////////////////////////////////////////
  // lock detector

  logic [3:0] good_cnt_r;
  logic [3:0] lock_need;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      gap_r <= '0;
    end
    else if (pfd_nxt == isd_pkg::PFD_IDLE)
    begin
      gap_r <= '0;
    end
    else if (gap_r != 8'hFF)
    begin
      gap_r <= gap_r + 8'h01;
    end
  end

  assign lock_need = ctrl_r[isd_pkg::CTRL_NEED_LSB +: 4];

  // new divider words restart the lock search from scratch
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      good_cnt_r <= '0;
    end
    else if (frame_take)
    begin
      good_cnt_r <= '0;
    end
    else if (cmp_done)
    begin
      if (gap_r < isd_pkg::LOCK_GAP_CYC)
      begin
        if (good_cnt_r != 4'hF)
        begin
          good_cnt_r <= good_cnt_r + 4'h1;
        end
      end
      else
      begin
        good_cnt_r <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      lock_r <= 1'b0;
    end
    else
    begin
      lock_r <= (good_cnt_r != '0) && (good_cnt_r >= lock_need);
    end
  end

  assign lock_flag = lock_r;

endmodule

// >>> hdl/isd_div.sv
// programmable event divider with a combinational wrap strobe
`timescale 1ns/100ps
module isd_div #(
  parameter int W = 11
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [W-1:0] ratio,
  output logic wrap
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] last;

  // a ratio of zero divides by one rather than stalling
  assign last = (ratio == '0) ? '0 : ratio - W'(1);
  assign wrap = tick && (cnt_r >= last);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
    end
    else if (wrap)
    begin
      cnt_r <= '0;
    end
    else if (tick)
    begin
      cnt_r <= cnt_r + W'(1);
    end
  end

endmodule

// >>> hdl/isd_pkg.sv
// shared constants and types of the synthesizer digital core
package isd_pkg;

  // serial write frame
  localparam int FRAME_BITS = 25;
  localparam logic [5:0] FRAME_LEN = 6'h19;
  localparam logic [5:0] CNT_MAX = 6'h3F;

  typedef struct packed {
    logic [3:0] chip;
    logic [4:0] addr;
    logic [15:0] data;
  } isd_frame_s;

  // serial register addresses
  localparam logic [4:0] SADDR_REF = 5'h00;
  localparam logic [4:0] SADDR_FB_LOW = 5'h01;
  localparam logic [4:0] SADDR_FB_HIGH = 5'h02;

  // serial register reset values
  localparam logic [15:0] REF_WORD_RST = 16'h0001;
  localparam logic [15:0] FB_LOW_RST = 16'h0400;
  localparam logic [15:0] FB_HIGH_RST = 16'h0000;

  // apb byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_REF = 8'h04;
  localparam logic [7:0] OFS_FB = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // control register fields
  localparam int CTRL_PRESC_BIT = 0;
  localparam int CTRL_NEED_LSB = 8;
  localparam logic [11:0] CTRL_RST = 12'h801;

  // status register fields
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_RATIO_ERR_BIT = 1;
  localparam int ST_OK_LSB = 8;
  localparam int ST_DROP_LSB = 16;

  // prescaler bases
  localparam logic [5:0] PRESC_SMALL = 6'h10;
  localparam logic [5:0] PRESC_BIG = 6'h20;
  localparam logic [17:0] NMIN_SMALL = 18'h00100;
  localparam logic [17:0] NMIN_BIG = 18'h00400;

  // lock window: lead/lag gaps must be shorter than this
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCK_GAP_NS = 30;
  localparam int LOCK_GAP_CYC_I = (LOCK_GAP_NS / CLK_PERIOD_NS) < 1 ?
                                  1 : (LOCK_GAP_NS / CLK_PERIOD_NS);
  localparam logic [7:0] LOCK_GAP_CYC = LOCK_GAP_CYC_I[7:0];

  typedef enum logic [1:0] {
    PFD_IDLE = 2'b00,
    PFD_LEAD = 2'b01,
    PFD_LAG = 2'b10
  } isd_pfd_e;

endpackage

// >>> testbench/isd_core_props.sv
// port-level assertions for the synthesizer core
`timescale 1ns/100ps
module isd_core_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ser_clk,
  input wire logic latch_strobe,
  input wire logic ser_data,
  input wire logic vco_in,
  input wire logic lead_pulse,
  input wire logic lag_pulse,
  input wire logic lock_flag
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  a_err_unmapped: assert property (pready && paddr > 8'h0C |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property
    (pready && paddr[1:0] == 2'b00 && paddr <= 8'h0C |-> !pslverr)
    else $error("error on mapped address");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error outside ready");
  a_rdata_hold: assert property
    (!$stable(prdata) |-> $past(psel && penable && !pwrite))
    else $error("read data moved without a read");
  a_pulse_excl: assert property (!(lead_pulse && lag_pulse))
    else $error("lead and lag together");
  a_lock_drop: assert property
    (lead_pulse [*4] ##1 !lead_pulse |-> ##[0:3] !lock_flag)
    else $error("lock kept after wide gap");
  c_unmapped: cover property (pready && pslverr);
  c_lock: cover property ($rose(lock_flag));
  c_lag: cover property ($rose(lag_pulse));
endmodule
bind isd_core isd_core_props u_props (.ref_clk(ref_clk), .rst(rst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ser_clk(ser_clk), .latch_strobe(latch_strobe), .ser_data(ser_data),
  .vco_in(vco_in), .lead_pulse(lead_pulse), .lag_pulse(lag_pulse),
  .lock_flag(lock_flag));

// >>> testbench/isd_core_tb.sv
// self-checking bench for the synthesizer core
`timescale 1ns/100ps
module isd_core_tb;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
  } isd_exp_s;
  localparam logic [3:0] CHIP = 4'h5; // arbitrary value
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic vco_in = 1'b0;
  logic vco_hold = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, ser_clk, latch_strobe, ser_data;
  logic lead_pulse, lag_pulse, lock_flag;
  logic [7:0] ok_n = 8'h00;
  logic [7:0] drop_n = 8'h00;
  int vcnt = 0;
  int checked = 0;
  int miscompares = 0;
  isd_exp_s exp_q[$];
  isd_exp_s ex;
  ////////////////////////////////////////////////////////////
  isd_core #(.CHIP_CODE(CHIP)) dut (.ref_clk(ref_clk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ser_clk(ser_clk), .latch_strobe(latch_strobe), .ser_data(ser_data),
    .vco_in(vco_in), .lead_pulse(lead_pulse), .lag_pulse(lag_pulse),
    .lock_flag(lock_flag));
  isd_host host (.ref_clk(ref_clk), .ser_clk(ser_clk),
    .latch_strobe(latch_strobe), .ser_data(ser_data));
  initial forever #5 ref_clk = ~ref_clk;
  // vco stand-in: nudges its period toward the reference edge so the
  // lock path is reached without an analog loop
  always @(posedge ref_clk)
    if (vco_hold || vcnt >= (lead_pulse ? 3 : (lag_pulse ? 5 : 4)))
    begin
      vco_in <= !vco_hold;
      vcnt <= 1;
    end
    else
    begin
      vco_in <= 1'b0;
      vcnt <= vcnt + 1;
    end
  ////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [32:0] seen, logic [32:0] want);
    checked++;
    if (seen !== want)
    begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", nm, want, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one idle cycle between transfers keeps every signal single-driven
  task automatic apb(logic [7:0] a, logic w, logic [31:0] d,
                     logic [31:0] m, logic e);
    exp_q.push_back(isd_exp_s'{w ? 32'h0 : d, w ? 32'h0 : m, e});
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic frame(logic [4:0] a, logic [15:0] d, int slow);
    host.send({7'h0, CHIP, a, d}, 25, slow);
    ok_n = ok_n + 8'h01;
  endtask
  task automatic sts(logic err, logic lk);
    apb(isd_pkg::OFS_STATUS, 1'b0, {8'h0, drop_n, ok_n, 6'h0, err, lk},
        32'h00FFFF03, 1'b0);
  endtask
  always @(posedge ref_clk)
    if (pready === 1'b1 && exp_q.size() > 0)
    begin
      ex = exp_q.pop_front();
      check("read", {pslverr, prdata & ex.m}, {ex.e, ex.d & ex.m});
    end
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    int r;
    logic [19:0] tab [7];
    tab = '{20'hC03FF, 20'h40400, 20'h7FFFF, 20'h800FF, 20'h00100,
            20'hA0000, 20'h40000};
    r = $urandom(32'h862E);
    tab[6] = {2'b01, 18'($urandom_range(262143, 1024))};
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(isd_pkg::OFS_CTRL, 1'b0, {20'h0, isd_pkg::CTRL_RST}, 32'hFFF, 1'b0);
    apb(isd_pkg::OFS_REF, 1'b1, 32'h7, 32'h0, 1'b0);
    apb(isd_pkg::OFS_REF, 1'b0, 32'h1, 32'hFFFF, 1'b0);
    apb(isd_pkg::OFS_FB, 1'b0, 32'h400, 32'h3FFFF, 1'b0);
    apb(8'h10, 1'b0, 32'h0, 32'hFFFFFFFF, 1'b1);
    sts(1'b0, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 3; i++)
    begin
      r = (i == 0) ? 1 : ((i == 1) ? 2047 : $urandom_range(2046, 2));
      frame(isd_pkg::SADDR_REF, r[15:0], i);
      apb(isd_pkg::OFS_REF, 1'b0, r, 32'hFFFF, 1'b0);
    end
    host.send({7'h0, CHIP, 5'h00, 16'h0ABC}, 24, 0);
    host.send({7'h0, CHIP, 5'h00, 16'h0ABC}, 26, 1);
    host.send({7'h0, CHIP ^ 4'h3, 5'h00, 16'h0ABC}, 25, 0);
    frame(5'h1F, 16'hFFFF, 0);
    drop_n = drop_n + 8'h03;
    apb(isd_pkg::OFS_REF, 1'b0, r, 32'hFFFF, 1'b0);
    sts(1'b0, 1'b0);
    $display("test frames done");
    for (int i = 0; i < 7; i++)
    begin
      apb(isd_pkg::OFS_CTRL, 1'b1, {20'h0, 4'h8, 7'h0, tab[i][18]},
          32'h0, 1'b0);
      frame(isd_pkg::SADDR_FB_HIGH, {14'h0, tab[i][17:16]}, 0);
      frame(isd_pkg::SADDR_FB_LOW, tab[i][15:0], 0);
      apb(isd_pkg::OFS_FB, 1'b0, {14'h0, tab[i][17:0]},
          32'h3FFFF, 1'b0);
      sts(tab[i][19], 1'b0);
    end
    $display("test ratio done");
    apb(isd_pkg::OFS_CTRL, 1'b1, 32'h800, 32'h0, 1'b0);
    frame(isd_pkg::SADDR_FB_LOW, 16'h0100, 0);
    frame(isd_pkg::SADDR_FB_HIGH, 16'h0000, 0);
    frame(isd_pkg::SADDR_REF, 16'h0400, 0);
    vco_hold <= 1'b0;
    for (r = 0; lock_flag !== 1'b1 && r < 60000; r++)
      @(posedge ref_clk);
    check("lock", {32'h0, lock_flag}, 33'h1);
    sts(1'b0, 1'b1);
    vco_hold <= 1'b1;
    repeat (1500) @(posedge ref_clk);
    check("pfd", {31'h0, lead_pulse, lag_pulse}, 33'h2);
    vco_hold <= 1'b0;
    for (r = 0; lead_pulse === 1'b1 && r < 3000; r++)
      @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    sts(1'b0, 1'b0);
    $display("test lock done");
    finish_test();
  end
endmodule

// >>> testbench/isd_host.sv
// serial host model writing frames into the core
`timescale 1ns/100ps
module isd_host (
  input wire logic ref_clk,
  output logic ser_clk,
  output logic latch_strobe,
  output logic ser_data
);
  initial
  begin
    ser_clk = 1'b0;
    latch_strobe = 1'b1;
    ser_data = 1'b0;
  end
  // shifts the nb low bits of f, msb first; slow stretches each level
  task automatic send(logic [31:0] f, int nb, int slow);
    @(posedge ref_clk);
    latch_strobe <= 1'b0;
    repeat (2 + slow) @(posedge ref_clk);
    for (int i = nb - 1; i >= 0; i--)
    begin
      ser_data <= f[i];
      ser_clk <= 1'b0;
      repeat (2 + slow) @(posedge ref_clk);
      ser_clk <= 1'b1;
      repeat (2 + slow) @(posedge ref_clk);
    end
    ser_clk <= 1'b0;
    repeat (2) @(posedge ref_clk);
    // released line shows the opposite level, never a stale bit
    ser_data <= ~ser_data;
    latch_strobe <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule
